// file: hw/cmf_pkg.sv
// Purpose: shared constants of the framer
// Assumes: byte-wide upstream stream, one MAC clock
// Notes: all field codes and overheads of the framer live here
package cmf_pkg;
    // extended header element codes
    localparam logic [3:0] ELEM_TYPE_SF_DOWN = 4'h5; // service flow, downstream
    localparam logic [3:0] ELEM_TYPE_SF_UP = 4'h6; // service flow, upstream
    localparam logic [3:0] ELEM_LEN_PHS = 4'h1; // index byte only
    localparam logic [3:0] ELEM_LEN_SYNC = 4'h2; // index plus grant sync byte
    localparam logic [3:0] ELEM_TYPE_PRIV_UP = 4'h3; // upstream privacy element
    localparam logic [3:0] ELEM_LEN_FRAG = 4'h5; // privacy with fragmentation
    localparam logic [3:0] FRAG_EH_VERSION = 4'h1; // version of the fragment element
    // fragment header frame control: type 11, parm 00011, ext header on
    localparam logic [1:0] FC_TYPE_MAC_MSG = 2'h3;
    localparam logic [4:0] FC_PARM_FRAG = 5'h03;
    localparam logic [7:0] FRAG_ELEN = 8'h06; // one byte type/len plus five value
    localparam logic [3:0] FRAG_HDR_BYTES = 4'ha; // fc, parm, len, six ext bytes
    localparam logic [3:0] HCS_BYTES = 4'h2;
    localparam logic [3:0] FRAGMENT_CRC_BYTES = 4'h4;
    localparam logic [15:0] FRAG_OVERHEAD = 16'h0010; // 16 bytes per fragment
    localparam logic [15:0] FRAG_MIN_GRANT = 16'h0011; // overhead plus one byte
    // byte positions counted from the header check sequence
    localparam logic [7:0] SUPPR_START_UP = 8'h01;
    localparam logic [7:0] SUPPR_START_DOWN = 8'h0d;
    localparam logic [7:0] CRYPT_START_PLAIN = 8'h0d;
    localparam logic [7:0] CRYPT_START_FRAG = 8'h01;
    localparam logic [7:0] PHS_MIN_SIZE = 8'h40; // 64 byte strings at least
    // crc seeds and polynomials
    localparam logic [15:0] HCS_INIT = 16'hffff;
    localparam logic [15:0] HCS_POLY = 16'h1021;
    localparam logic [31:0] FRAGMENT_CRC_INIT = 32'hffff_ffff;
    localparam logic [31:0] FRAGMENT_CRC_POLY = 32'h04c1_1db7;
    // framer states, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_HDR = 5'b00010,
        ST_HCS = 5'b00100,
        ST_DATA = 5'b01000,
        ST_FRAGMENT_CRC = 5'b10000
    } cmf_state_t;
endpackage : cmf_pkg

// file: hw/cmf_framer.sv
// Purpose: upstream framer of a cable modem: suppression element and fragmentation
// Assumes: inputs synchronous to mclk; grants of at least 17 bytes when fragmenting
// Notes: suppressed bytes are dropped and kept out of every count and crc
`timescale 1ns/100ps

// Summary of operation
// R1: element type 5/6, length 1, index byte
// R2: index 0 or no element: no suppression
// R3: suppressed strings of 64 bytes accepted
// R4: upstream suppression starts after check sequence
// R5: downstream suppression starts at thirteenth byte
// R6: crypt start 13 plain, 1 fragmented
// R7: packet crc skips suppressed bytes
// R8: sync element type 6, length 2, queue+grants
// R9: omit sync byte for non-unsolicited flows
// R10: fragment when grant below requested length
// R11: fit payload per grant, new header each
// R12: fragment frame control 11, parameter 00011
// R13: four-bit sequence, plus one per fragment
// R14: first/last flags only on those fragments
// R15: head-end checks sequence increments
// R16: last fragment request means next frame
// R17: fixed header, 16 bytes total overhead
// R18: privacy element always; copy or clear enable
// R19: fragment sid equals partial grant sid
// R20: separate crc appended to each fragment
// R21: head-end grants hold 17 bytes minimum
// R22: no key messages in concatenation with privacy; code blocks them only if frag_enable is set
// R23: five-byte fragment element value layout
module cmf_framer
    import cmf_pkg::*;
#(
    parameter int LEN_W = 16 // width of byte lengths
) (
    input wire logic mclk,
    input wire logic rst_n,
    // suppression element request
    input wire logic phs_req,
    input wire logic phs_downstream,
    input wire logic phs_present,
    input wire logic [7:0] suppression_index,
    input wire logic ugs_flow,
    input wire logic queue_indicator,
    input wire logic [6:0] active_grants,
    input wire logic [7:0] suppressed_string_len,
    output logic phs_valid_ff,
    output logic phs_active_ff,
    output logic phs_reject_ff,
    output logic [7:0] ext_element_type_len_ff,
    output logic [7:0] ext_element_value0_ff,
    output logic [7:0] ext_element_value1_ff,
    output logic [7:0] suppr_start_ff,
    // frame and grant
    input wire logic frag_enable,
    input wire logic concat_enable,
    input wire logic privacy_in_use,
    input wire logic key_msg_pending,
    input wire logic frame_start,
    input wire logic [LEN_W-1:0] frame_len,
    input wire logic [LEN_W-1:0] req_len,
    input wire logic grant_valid,
    input wire logic [LEN_W-1:0] grant_len,
    input wire logic [13:0] grant_sid,
    input wire logic [3:0] key_seq,
    input wire logic orig_privacy_enable_bit,
    input wire logic key_toggle,
    input wire logic [7:0] frag_req,
    input wire logic [7:0] next_frame_req,
    // payload stream in
    input wire logic in_valid,
    input wire logic [7:0] in_data,
    input wire logic in_suppressed,
    output logic in_ready_ff,
    // framed stream out
    output logic out_valid_ff,
    output logic [7:0] out_data_ff,
    output logic busy_ff,
    output logic frag_active_ff,
    output logic [7:0] crypt_start_ff,
    output logic concat_allowed_ff,
    output logic [31:0] pkt_crc_ff
);
    cmf_state_t state_ff; // framer state
    logic [LEN_W-1:0] remain_ff; // frame bytes not yet sent
    logic [LEN_W-1:0] cnt_ff; // payload bytes left in this grant
    logic [LEN_W-1:0] flen_ff; // LEN field of current fragment
    logic [3:0] idx_ff; // byte index within header, hcs or fragment_crc
    logic [3:0] seq_ff; // sequence of the current fragment
    logic [3:0] seed_ff; // free running start value for new frames
    logic first_ff; // current fragment is the first
    logic last_ff; // current fragment is the last
    logic [13:0] sid_ff; // sid latched from partial grant
    logic [15:0] hcs_ff; // running header check
    logic [31:0] fragment_crc_ff; // running fragment crc
    logic [31:0] pcrc_ff; // running packet crc
    logic [7:0] hdr_byte; // current header byte
    logic take; // payload byte accepted this cycle
    logic [LEN_W-1:0] fit; // payload that fits the grant
    logic frag_go; // grant starts or continues fragmentation

    // msb first crc over one byte
    function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ d[i]) ? ((r << 1) ^ HCS_POLY) : (r << 1);
        end
        return r;
    endfunction : crc16

    function automatic logic [31:0] crc32(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[31] ^ d[i]) ? ((r << 1) ^ FRAGMENT_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc32

    // fragment header bytes, ten of them before the check sequence
    always_comb begin
        case (idx_ff)
            4'h0: hdr_byte = {FC_TYPE_MAC_MSG, FC_PARM_FRAG, 1'b1}; // [R12]
            4'h1: hdr_byte = FRAG_ELEN; // [R17]
            4'h2: hdr_byte = flen_ff[15:8];
            4'h3: hdr_byte = flen_ff[7:0];
            4'h4: hdr_byte = {ELEM_TYPE_PRIV_UP, ELEM_LEN_FRAG}; // [R23]
            4'h5: hdr_byte = {key_seq, FRAG_EH_VERSION}; // [R18]
            // enable copied only while privacy runs, else cleared
            4'h6: hdr_byte = {privacy_in_use & orig_privacy_enable_bit, key_toggle,
                              sid_ff[13:8]}; // [R18] [R19]
            4'h7: hdr_byte = sid_ff[7:0]; // [R19]
            // request belongs to the next frame on the last fragment
            4'h8: hdr_byte = last_ff ? next_frame_req : frag_req; // [R16]
            4'h9: hdr_byte = {2'b00, first_ff, last_ff, seq_ff}; // [R13] [R14] [R23]
            default: hdr_byte = 8'h00;
        endcase
    end

    // a short grant starts fragmenting; later grants continue it
    assign frag_go = frag_enable & (frag_active_ff | (grant_len < req_len)); // [R10]
    // payload that fits after the 16 byte overhead
    assign fit = ((grant_len - FRAG_OVERHEAD) < remain_ff) ?
                 (grant_len - FRAG_OVERHEAD) : remain_ff; // [R11]
    assign take = (state_ff == ST_DATA) & in_valid & in_ready_ff;

    // suppression and sync element build-up
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            phs_valid_ff <= 1'b0;
            phs_active_ff <= 1'b0;
            phs_reject_ff <= 1'b0;
            ext_element_type_len_ff <= 8'h00;
            ext_element_value0_ff <= 8'h00;
            ext_element_value1_ff <= 8'h00;
            suppr_start_ff <= SUPPR_START_UP;
        end else begin
            phs_valid_ff <= phs_req;
            if (phs_req) begin
                // index 0 or absent element both mean plain packet
                phs_active_ff <= phs_present & (suppression_index != 8'h00); // [R2]
                // strings over 64 bytes are refused here
                phs_reject_ff <= phs_present & (suppression_index != 8'h00) &
                                 (suppressed_string_len > PHS_MIN_SIZE); // [R3]
                // upstream after the check sequence, downstream past the addresses
                suppr_start_ff <= phs_downstream ? SUPPR_START_DOWN :
                                  SUPPR_START_UP; // [R4] [R5]
                ext_element_value0_ff <= suppression_index; // [R1] [R8]
                if (!phs_downstream && ugs_flow) begin
                    // sync byte only on unsolicited grant flows
                    ext_element_type_len_ff <= {ELEM_TYPE_SF_UP, ELEM_LEN_SYNC}; // [R8] [R9]
                    ext_element_value1_ff <= {queue_indicator, active_grants}; // [R8]
                end else begin
                    ext_element_type_len_ff <= {phs_downstream ? ELEM_TYPE_SF_DOWN :
                                                ELEM_TYPE_SF_UP, ELEM_LEN_PHS}; // [R1] [R9]
                    ext_element_value1_ff <= 8'h00;
                end
            end
        end
    end

    // concatenation permission and encryption offset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            concat_allowed_ff <= 1'b0;
            crypt_start_ff <= CRYPT_START_PLAIN;
        end else begin
            // key messages stay out when frag_enable and privacy_in_use are set, so that they are never encrypted
            concat_allowed_ff <= concat_enable & ~(frag_enable & privacy_in_use &
                                 key_msg_pending); // [R22]
            crypt_start_ff <= frag_active_ff ? CRYPT_START_FRAG :
                              CRYPT_START_PLAIN; // [R6]
        end
    end

    // sequence start seed: any value is legal, a free counter spreads them
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            seed_ff <= 4'h0;
        end else begin
            seed_ff <= seed_ff + 4'h1;
        end
    end

    // main framer
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            remain_ff <= '0;
            cnt_ff <= '0;
            flen_ff <= '0;
            idx_ff <= 4'h0;
            seq_ff <= 4'h0;
            first_ff <= 1'b0;
            last_ff <= 1'b0;
            sid_ff <= 14'h0000;
            hcs_ff <= HCS_INIT;
            fragment_crc_ff <= FRAGMENT_CRC_INIT;
            pcrc_ff <= FRAGMENT_CRC_INIT;
            pkt_crc_ff <= 32'h0000_0000;
            frag_active_ff <= 1'b0;
            in_ready_ff <= 1'b0;
            out_valid_ff <= 1'b0;
            out_data_ff <= 8'h00;
            busy_ff <= 1'b0;
        end else begin
            out_valid_ff <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    busy_ff <= 1'b0;
                    if (frame_start) begin
                        remain_ff <= frame_len;
                        pcrc_ff <= FRAGMENT_CRC_INIT;
                        frag_active_ff <= 1'b0;
                    end else if (grant_valid && remain_ff != '0) begin
                        busy_ff <= 1'b1;
                        if (frag_go && grant_len >= FRAG_MIN_GRANT) begin
                            // new header for every fragment
                            state_ff <= ST_HDR; // [R11]
                            cnt_ff <= fit;
                            flen_ff <= LEN_W'(fit + FRAG_ELEN + FRAGMENT_CRC_BYTES); // [R17]
                            first_ff <= ~frag_active_ff; // [R14]
                            last_ff <= (fit == remain_ff); // [R14]
                            seq_ff <= frag_active_ff ? seq_ff + 4'h1 : seed_ff; // [R13]
                            if (!frag_active_ff) begin
                                sid_ff <= grant_sid; // [R19]
                            end
                            frag_active_ff <= 1'b1;
                            idx_ff <= 4'h0;
                            hcs_ff <= HCS_INIT;
                        end else if (!frag_go) begin
                            // whole frame goes out unfragmented
                            state_ff <= ST_DATA;
                            cnt_ff <= remain_ff;
                            in_ready_ff <= 1'b1;
                        end else begin
                            busy_ff <= 1'b0; // undersized grant is dropped
                        end
                    end
                end
                ST_HDR: begin
                    out_valid_ff <= 1'b1;
                    out_data_ff <= hdr_byte;
                    hcs_ff <= crc16(hcs_ff, hdr_byte);
                    idx_ff <= idx_ff + 4'h1;
                    if (idx_ff == FRAG_HDR_BYTES - 4'h1) begin
                        state_ff <= ST_HCS;
                        idx_ff <= 4'h0;
                    end
                end
                ST_HCS: begin
                    out_valid_ff <= 1'b1;
                    out_data_ff <= (idx_ff == 4'h0) ? ~hcs_ff[15:8] : ~hcs_ff[7:0];
                    idx_ff <= idx_ff + 4'h1;
                    if (idx_ff == HCS_BYTES - 4'h1) begin
                        state_ff <= ST_DATA;
                        idx_ff <= 4'h0;
                        fragment_crc_ff <= FRAGMENT_CRC_INIT;
                        in_ready_ff <= 1'b1;
                    end
                end
                ST_DATA: begin
                    if (take && in_suppressed) begin
                        // suppressed byte: not sent, not counted, not in a crc
                    end else if (take) begin
                        out_valid_ff <= 1'b1;
                        out_data_ff <= in_data;
                        pcrc_ff <= crc32(pcrc_ff, in_data); // [R7]
                        fragment_crc_ff <= crc32(fragment_crc_ff, in_data); // [R20]
                        cnt_ff <= cnt_ff - LEN_W'(1);
                        remain_ff <= remain_ff - LEN_W'(1);
                        if (cnt_ff == LEN_W'(1)) begin
                            in_ready_ff <= 1'b0;
                            if (frag_active_ff) begin
                                state_ff <= ST_FRAGMENT_CRC; // [R20]
                            end else begin
                                state_ff <= ST_IDLE;
                                pkt_crc_ff <= ~crc32(pcrc_ff, in_data); // [R7]
                            end
                        end
                    end
                end
                ST_FRAGMENT_CRC: begin
                    // fragment crc, msb first
                    out_valid_ff <= 1'b1;
                    out_data_ff <= ~fragment_crc_ff[31:24]; // [R20]
                    fragment_crc_ff <= fragment_crc_ff << 8;
                    idx_ff <= idx_ff + 4'h1;
                    if (idx_ff == FRAGMENT_CRC_BYTES - 4'h1) begin
                        state_ff <= ST_IDLE;
                        if (last_ff) begin
                            pkt_crc_ff <= ~pcrc_ff;
                            frag_active_ff <= 1'b0; // frame done [R6]
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // checks
    chk_fc_byte: assert property (@(posedge mclk) disable iff (!rst_n) // [R12]
        (state_ff == ST_HDR && idx_ff == 4'h0) |=> (out_data_ff == 8'hc7))
        else $error("fragment frame control byte wrong");
    chk_phs_type: assert property (@(posedge mclk) disable iff (!rst_n) // [R1]
        phs_req && phs_downstream |=> ext_element_type_len_ff == 8'h51)
        else $error("downstream element header wrong");
    chk_sync_omit: assert property (@(posedge mclk) disable iff (!rst_n) // [R9]
        phs_req && !ugs_flow |=> ext_element_type_len_ff[3:0] == 4'h1
        && ext_element_value1_ff == 8'h00)
        else $error("sync byte sent on a non-unsolicited flow");
    chk_phs_zero: assert property (@(posedge mclk) disable iff (!rst_n) // [R2]
        phs_req && suppression_index == 8'h00 |=> !phs_active_ff)
        else $error("index zero marked as suppressed");
    chk_seq_step: assert property (@(posedge mclk) disable iff (!rst_n) // [R13]
        (state_ff == ST_IDLE && grant_valid && !frame_start && frag_active_ff
         && frag_enable && remain_ff != '0 && grant_len >= 16'h0011)
        |=> seq_ff == $past(seq_ff) + 4'h1)
        else $error("fragment sequence did not step by one");
    chk_mid_flags: assert property (@(posedge mclk) disable iff (!rst_n) // [R14]
        $rose(state_ff == ST_HDR) && !first_ff |-> $past(frag_active_ff))
        else $error("first flag missing on opening fragment");
    chk_overhead: assert property (@(posedge mclk) disable iff (!rst_n) // [R17]
        $rose(state_ff == ST_HDR) |-> flen_ff == cnt_ff + 16'h000a)
        else $error("fragment length field wrong");
    chk_sid_keep: assert property (@(posedge mclk) disable iff (!rst_n) // [R19]
        state_ff == ST_HDR && !first_ff |-> $stable(sid_ff))
        else $error("fragment sid changed within frame");
    chk_crypt_pos: assert property (@(posedge mclk) disable iff (!rst_n) // [R6]
        frag_active_ff ##1 frag_active_ff |-> crypt_start_ff == 8'h01)
        else $error("encryption offset wrong while fragmenting");
    chk_key_concat: assert property (@(posedge mclk) disable iff (!rst_n) // [R22]
        frag_enable && privacy_in_use && key_msg_pending |=> !concat_allowed_ff)
        else $error("key message allowed into concatenation");
    chk_hdr_len: assert property (@(posedge mclk) disable iff (!rst_n) // [R11]
        $rose(state_ff == ST_HDR) |-> ##10 state_ff == ST_HCS ##2 state_ff == ST_DATA)
        else $error("fragment header not ten plus two bytes");
endmodule : cmf_framer

// file: tb/cmf_headend_model.sv
// Purpose: head-end model: grants bursts, collects bytes
// Assumes: one grant at a time, stream sampled on mclk
// Notes: checks the sequence count of each fragment whose first flag is clear
`timescale 1ns/100ps
module cmf_headend_model
    import cmf_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic out_valid_ff,
    input wire logic [7:0] out_data_ff,
    input wire logic busy_ff,
    output logic grant_valid,
    output logic [15:0] grant_len,
    output logic [13:0] grant_sid,
    output int seq_errs
);
    logic [7:0] rx_q[$]; // every byte seen on the upstream
    int idx; // byte position inside the current burst
    logic [3:0] last_seq; // count of the previous fragment
    initial begin
        grant_valid = 1'b0;
        grant_len = 16'h0000;
        grant_sid = 14'h0000;
    end
    // one-cycle grant of 17 bytes or more; a shorter one tests refusal
    task automatic give_grant(input logic [15:0] len, input logic [13:0] service_identifier);
        @(posedge mclk);
        grant_valid <= 1'b1;
        grant_len <= len;
        grant_sid <= service_identifier;
        @(posedge mclk);
        grant_valid <= 1'b0;
        // released fields flip, so nothing stale looks valid
        grant_len <= ~len;
        grant_sid <= ~service_identifier;
    endtask : give_grant
    // collect bytes; byte 9 holds flags and sequence
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            idx <= 0;
            seq_errs <= 0;
        end else begin
            if (out_valid_ff) begin
                rx_q.push_back(out_data_ff);
            end
            if (!busy_ff) begin
                idx <= 0;
            end else if (out_valid_ff) begin
                idx <= idx + 1;
                if (idx == 9) begin
                    last_seq <= out_data_ff[3:0];
                    // later fragments step the count by one
                    if (!out_data_ff[5] && out_data_ff[3:0] !== last_seq + 4'h1) begin
                        seq_errs <= seq_errs + 1;
                    end
                end
            end
        end
    end
endmodule : cmf_headend_model

// file: tb/cmf_framer_bench.sv
// Purpose: self-checking bench of the framer
// Assumes: head-end model grants and collects
// Notes: payload source holds each byte until taken
`timescale 1ns/100ps
module cmf_framer_bench;
    import cmf_pkg::*;
    logic mclk, rst_n, phs_req, phs_downstream, phs_present, ugs_flow, queue_indicator;
    logic [7:0] suppression_index, suppressed_string_len, frag_req, next_frame_req, in_data;
    logic [6:0] active_grants;
    logic frag_enable, concat_enable, privacy_in_use, key_msg_pending, frame_start;
    logic [15:0] frame_len, req_len, grant_len;
    logic grant_valid, orig_privacy_enable_bit, key_toggle, in_valid, in_suppressed;
    logic [13:0] grant_sid;
    logic [3:0] key_seq;
    logic phs_valid_ff, phs_active_ff, phs_reject_ff, in_ready_ff, out_valid_ff, busy_ff;
    logic [7:0] ext_element_type_len_ff, ext_element_value0_ff, ext_element_value1_ff;
    logic [7:0] suppr_start_ff, out_data_ff, crypt_start_ff;
    logic frag_active_ff, concat_allowed_ff;
    logic [31:0] pkt_crc_ff;
    int num_errors = 0, tests_run = 0, pidx = 0, seq_errs;
    logic [7:0] pay[$]; // payload offered to the framer
    logic sup[$]; // per-byte suppressed flag
    cmf_framer cmf_framer_inst (.*);
    cmf_headend_model cmf_headend_model_inst (.*);
    // payload source: next byte once the current one is taken
    always @(posedge mclk) begin
        if (in_valid && in_ready_ff) pidx = pidx + 1;
        in_valid <= (pidx < pay.size());
        in_data <= (pidx < pay.size()) ? pay[pidx] : ~in_data;
        in_suppressed <= (pidx < pay.size()) ? sup[pidx] : 1'b0;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        if (num_errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up
    // reference crc of sent bytes, inverted at the end
    function automatic logic [31:0] crc32(input logic [7:0] b[$]);
        logic [31:0] c;
        c = FRAGMENT_CRC_INIT;
        foreach (b[i]) for (int k = 7; k >= 0; k--)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ b[i][k]) ? FRAGMENT_CRC_POLY : 32'h0000_0000);
        return ~c;
    endfunction : crc32
    // grant one burst, then wait (bounded) for idle
    task automatic serve(input logic [15:0] len, input logic [13:0] service_identifier);
        int n = 0;
        cmf_headend_model_inst.give_grant(len, service_identifier);
        repeat (2) @(negedge mclk);
        while (busy_ff !== 1'b0 && n < 400) begin
            @(negedge mclk);
            n++;
        end
        check(n < 400, 1);
    endtask : serve
    task automatic payload_header_suppression(input logic dn, pr, input logic [7:0] ix, input logic ug,
            input logic [7:0] sl, tl, v0, v1, input logic ac, rj);
        @(posedge mclk);
        {phs_req, phs_downstream, phs_present, suppression_index} <= {1'b1, dn, pr, ix};
        {ugs_flow, suppressed_string_len, queue_indicator, active_grants} <= {ug, sl, 8'h85};
        @(posedge mclk);
        phs_req <= 1'b0;
        @(negedge mclk);
        check(phs_valid_ff, 1);
        check(phs_active_ff, ac);
        check(phs_reject_ff, rj);
        if (pr) begin
            check(ext_element_type_len_ff, tl);
            check(ext_element_value0_ff, v0);
            check(ext_element_value1_ff, v1);
            check(suppr_start_ff, dn ? SUPPR_START_DOWN : SUPPR_START_UP);
        end
        @(negedge mclk);
        check(phs_valid_ff, 0);
    endtask : payload_header_suppression
    task automatic load(input logic [7:0] p[$], input logic s[$]);
        @(negedge mclk);
        pay = p;
        sup = s;
        pidx = 0;
        cmf_headend_model_inst.rx_q.delete();
    endtask : load
    // plain frame; one suppressed byte leaves stream and crc
    task automatic plain_frame();
        logic [7:0] q[$];
        load('{8'h11, 8'h22, 8'h33, 8'h44}, '{0, 1, 0, 0});
        @(posedge mclk);
        {frame_start, frame_len, req_len, frag_enable} <= {1'b1, 16'h0003, 16'h0003, 1'b0};
        @(posedge mclk);
        frame_start <= 1'b0;
        serve(16'h0064, 14'h0001);
        q = cmf_headend_model_inst.rx_q;
        check(q.size(), 3);
        check({q[0], q[1], q[2]}, 24'h11_3344);
        check(pkt_crc_ff, crc32('{8'h11, 8'h33, 8'h44}));
        check(crypt_start_ff, CRYPT_START_PLAIN);
    endtask : plain_frame
    // one fragment: header fields, payload slice and total size
    task automatic chk_frag(input int n, input logic f, l, input int p0, output logic [3:0] s);
        logic [7:0] q[$];
        q = cmf_headend_model_inst.rx_q;
        check(q.size(), n + 16);
        check(q[0], {FC_TYPE_MAC_MSG, FC_PARM_FRAG, 1'b1});
        check(q[1], FRAG_ELEN);
        check({q[2], q[3]}, n + 10);
        check({q[4], q[5], q[6], q[7]}, 32'h35a1_d234);
        check(q[8], l ? 8'h5a : 8'h21);
        check(q[9][7:4], {2'b00, f, l});
        for (int i = 0; i < n; i++) check(q[12 + i], pay[p0 + i]);
        check({q[n + 12], q[n + 13], q[n + 14], q[n + 15]}, crc32(q[12:n + 11]));
        s = q[9][3:0];
        cmf_headend_model_inst.rx_q.delete();
    endtask : chk_frag
    task automatic frag_frame();
        logic [3:0] s0, s1;
        load('{8'ha1, 8'hb2, 8'hc3}, '{0, 0, 0});
        @(posedge mclk);
        {frag_enable, privacy_in_use, orig_privacy_enable_bit, key_toggle} <= 4'hf;
        {key_seq, frag_req, next_frame_req} <= {4'ha, 8'h21, 8'h5a};
        {frame_start, frame_len, req_len} <= {1'b1, 16'h0003, 16'h0032};
        @(posedge mclk);
        frame_start <= 1'b0;
        serve(16'h0012, 14'h1234);
        check(frag_active_ff, 1);
        check(crypt_start_ff, CRYPT_START_FRAG);
        chk_frag(2, 1, 0, 0, s0);
        serve(16'h000a, 14'h1234);
        check(cmf_headend_model_inst.rx_q.size(), 0);
        serve(16'h0028, 14'h0abc);
        chk_frag(1, 0, 1, 2, s1);
        check(s1, 4'(s0 + 4'h1));
        check(seq_errs, 0);
        check(crypt_start_ff, CRYPT_START_PLAIN);
    endtask : frag_frame
    // key messages stay out of concatenation
    task automatic concat_rule();
        @(posedge mclk);
        {concat_enable, key_msg_pending} <= 2'b11;
        repeat (2) @(negedge mclk);
        check(concat_allowed_ff, 0);
        @(posedge mclk);
        key_msg_pending <= 1'b0;
        repeat (2) @(negedge mclk);
        check(concat_allowed_ff, 1);
    endtask : concat_rule
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    initial begin
        {rst_n, phs_req, phs_downstream, phs_present, ugs_flow, queue_indicator} = '0;
        {suppression_index, suppressed_string_len, frag_req, next_frame_req} = '0;
        {active_grants, frag_enable, concat_enable, privacy_in_use, key_msg_pending} = '0;
        {frame_start, frame_len, req_len, orig_privacy_enable_bit, key_toggle, key_seq} = '0;
        {in_valid, in_data, in_suppressed} = '0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        check(suppr_start_ff, 8'h01);
        check(crypt_start_ff, 8'h0d);
        payload_header_suppression(1, 1, 8'h07, 1, 8'h40, 8'h51, 8'h07, 8'h00, 1, 0);
        payload_header_suppression(0, 1, 8'hff, 0, 8'h41, 8'h61, 8'hff, 8'h00, 1, 1);
        payload_header_suppression(0, 1, 8'h03, 1, 8'h20, 8'h62, 8'h03, 8'h85, 1, 0);
        payload_header_suppression(0, 1, 8'h00, 0, 8'h40, 8'h61, 8'h00, 8'h00, 0, 0);
        payload_header_suppression(0, 0, 8'h09, 0, 8'h40, 8'h00, 8'h00, 8'h00, 0, 0);
        plain_frame();
        frag_frame();
        concat_rule();
        wrap_up();
    end
    // watchdog: the run needs under a thousand cycles
    initial begin
        #(4000 * 5);
        num_errors++;
        wrap_up();
    end
endmodule : cmf_framer_bench
